//--- logic/aeap_pkg.sv
// constants shared by the active energy accumulator and pulse output blocks
// Contract
// - add each active power sample into a 49-bit signed accumulator every four clocks.
// - visible energy register shows only the top 24 accumulator bits.
// - accumulation is signed; negative samples reduce the energy.
// - positive-only mode adds positive samples only; negatives add nothing.
// - mode bit 15 selects positive-only, affects active energy only, off at reset.
// - samples divided by an 8-bit unsigned divisor; zero divides by one.
// - read-clear read returns visible energy, then zeroes accumulator top 24 bits.
// - active power goes to waveform output when source field is zero and enable set.
// - waveform rates 27.9, 14, 7 or 3.5 thousand samples per second.
// - waveform samples count as settled only about 2 ms after source selection.
// - visible energy wraps past full scale and keeps counting in the same direction.
// - flag events for half full in either sign and for overflow or underflow.
// - signed 16-bit offset added to power; 256 counts equal one sample LSB.
// - converter makes one internal pulse per visible energy LSB advanced.
// - output pulse per (den+1)/(num+1) internal pulses, 12-bit unsigned scaling values.
// - a scaling value of zero is used as one.
// - scaling ratio above one is clamped to exactly one.
// - with ratio one the output pulse lasts 16 periods of clock divided by four.
// - pulse width fixed at 90 ms when period is at least 360 ms, else 50 percent duty.
package aeap_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned ACC_W = 49;
    localparam int unsigned VIS_W = 24;
    localparam int unsigned VIS_LSB = ACC_W - VIS_W;
    localparam int unsigned PWR_W = 24;
    localparam int unsigned OFS_W = 16;
    localparam int unsigned TRIM_FRAC = 8;
    localparam int unsigned TRIM_W = PWR_W + TRIM_FRAC + 1;
    localparam int unsigned DIV_W = 8;
    localparam int unsigned SCALE_W = 12;
    localparam int unsigned ADV_W = 10;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned MODE_W = 16;
    localparam int unsigned MODE_POS_ONLY_BIT = 15;
    localparam int unsigned MODE_WSRC_HI = 14;
    localparam int unsigned MODE_WSRC_LO = 13;
    localparam int unsigned MODE_WRATE_HI = 12;
    localparam int unsigned MODE_WRATE_LO = 11;
    localparam logic [1:0] WSRC_ACTIVE_POWER = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [1:0] STEP_LAST = 2'h3;
    localparam int unsigned STEP_DIV = 4;
    localparam int unsigned CF_RATIO1_TICKS = 16;
    localparam int unsigned CF_RATIO1_CYC = CF_RATIO1_TICKS * STEP_DIV;
    localparam int unsigned CF_FIXED_WIDTH_MS = 90;
    localparam int unsigned CF_HALF_LIMIT_MS = 180;
    localparam int unsigned WAVE_SETTLE_MS = 2;
    localparam int unsigned WAVE_BASE_SPS = 27900;
    localparam int unsigned WAVE_BASE_CYC = CLK_HZ / WAVE_BASE_SPS;
    localparam int unsigned CF_FIXED_WIDTH_CYC = CF_FIXED_WIDTH_MS * (CLK_HZ / 1000);
    localparam int unsigned CF_SLOW_PERIOD_CYC = 2 * CF_HALF_LIMIT_MS * (CLK_HZ / 1000);
    localparam int unsigned WAVE_SETTLE_CYC = WAVE_SETTLE_MS * (CLK_HZ / 1000);
endpackage

//--- logic/aeap_pulse_gen.sv
// energy-to-pulse converter: ratio scaling and calibration pulse shaping
`timescale 1ns/1ps
`default_nettype none
module aeap_pulse_gen
    import aeap_pkg::*;
#(
    parameter int unsigned FIXED_WIDTH_CYC = CF_FIXED_WIDTH_CYC,
    parameter int unsigned SLOW_PERIOD_CYC = CF_SLOW_PERIOD_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // energy advance from the accumulator
    input wire logic step_i,
    input wire logic [ADV_W-1:0] advance,
    // scaling registers
    input wire logic [SCALE_W-1:0] pulse_rate_numerator,
    input wire logic [SCALE_W-1:0] pulse_rate_denominator,
    // pulse pin
    output logic calibration_pulse_out
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HIGH = 3'h2,
        ST_LOW = 3'h4
    } aeap_cf_state_t;

    function automatic logic [SCALE_W:0] scale_eff(input logic [SCALE_W-1:0] v);
        logic [SCALE_W:0] r;
        r = (v == '0) ? (SCALE_W+1)'(1) : {1'b0, v};
        return r + (SCALE_W+1)'(1);
    endfunction

    aeap_cf_state_t state_r, state_nxt;
    logic [31:0] frac_r, frac_nxt;
    logic [CNT_W-1:0] period_r, tcnt_r, width_r, width_nxt;
    logic [SCALE_W:0] num_e, den_e;
    logic [ADV_W+SCALE_W:0] prod;
    logic fire, ratio_one;

    always_comb begin
        num_e = scale_eff(pulse_rate_numerator);
        den_e = scale_eff(pulse_rate_denominator);
        if (num_e > den_e) begin
            num_e = den_e;
        end
        ratio_one = (num_e == den_e);
        prod = {{(SCALE_W+1){1'b0}}, advance} * {{ADV_W{1'b0}}, num_e};
        // internal pulses weighted by num, output every den
        fire = (state_r == ST_IDLE) && (frac_r >= 32'(den_e));
        frac_nxt = frac_r;
        if (step_i) begin
            frac_nxt = frac_nxt + 32'(prod);
        end
        if (fire) begin
            frac_nxt = frac_nxt - 32'(den_e);
        end
    end

    // width picked from the previous period, so the first pulse is long
    always_comb begin
        if (ratio_one) begin
            width_nxt = CNT_W'(CF_RATIO1_CYC);
        end else if (period_r >= CNT_W'(SLOW_PERIOD_CYC)) begin
            width_nxt = CNT_W'(FIXED_WIDTH_CYC);
        end else if (period_r < CNT_W'(2)) begin
            width_nxt = CNT_W'(1);
        end else begin
            width_nxt = period_r >> 1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (fire) begin
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tcnt_r == '0) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (tcnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ST_IDLE;
            frac_r <= '0;
        end else begin
            state_r <= state_nxt;
            frac_r <= frac_nxt;
        end
    end

    // low phase as long as the high phase keeps duty at most half
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tcnt_r <= '0;
            width_r <= '0;
        end else if (fire) begin
            width_r <= width_nxt;
            tcnt_r <= width_nxt - CNT_W'(1);
        end else if (state_r == ST_HIGH && tcnt_r == '0) begin
            tcnt_r <= width_r - CNT_W'(1);
        end else if (tcnt_r != '0) begin
            tcnt_r <= tcnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            period_r <= CNT_W'(SLOW_PERIOD_CYC);
        end else if (fire) begin
            period_r <= CNT_W'(1);
        end else if (period_r < CNT_W'(SLOW_PERIOD_CYC)) begin
            period_r <= period_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            calibration_pulse_out <= 1'b0;
        end else begin
            calibration_pulse_out <= (state_nxt == ST_HIGH);
        end
    end
endmodule
`default_nettype wire

//--- logic/aeap_wave_tap.sv
// waveform tap of trimmed active power with rate select and settling
`timescale 1ns/1ps
`default_nettype none
module aeap_wave_tap
    import aeap_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = WAVE_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // selection and source
    input wire logic select_active,
    input wire logic [1:0] rate_sel,
    input wire logic [PWR_W-1:0] power_word,
    // waveform output
    output logic [PWR_W-1:0] waveform_sample,
    output logic waveform_sample_valid,
    output logic waveform_settled
);
    logic [CNT_W-1:0] rate_cnt_r, settle_cnt_r, period;

    assign period = CNT_W'(WAVE_BASE_CYC) << rate_sel;

    // settling restarts whenever the source is deselected
    always_ff @(posedge clk_sys) begin
        if (srst || !select_active) begin
            settle_cnt_r <= '0;
            waveform_settled <= 1'b0;
        end else if (settle_cnt_r >= CNT_W'(SETTLE_CYC - 1)) begin
            waveform_settled <= 1'b1;
        end else begin
            settle_cnt_r <= settle_cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !select_active || rate_cnt_r >= period - CNT_W'(1)) begin
            rate_cnt_r <= '0;
        end else begin
            rate_cnt_r <= rate_cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            waveform_sample <= '0;
            waveform_sample_valid <= 1'b0;
        end else begin
            waveform_sample_valid <= 1'b0;
            // a deselect in the settled cycle must not leak one last sample
            if (select_active && waveform_settled && rate_cnt_r == period - CNT_W'(1)) begin
                waveform_sample <= power_word;
                waveform_sample_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/aeap_energy_core.sv
// active energy accumulator with read-clear, wrap events, waveform and pulse output
`timescale 1ns/1ps
`default_nettype none
module aeap_energy_core
    import aeap_pkg::*;
#(
    parameter int unsigned FIXED_WIDTH_CYC = CF_FIXED_WIDTH_CYC,
    parameter int unsigned SLOW_PERIOD_CYC = CF_SLOW_PERIOD_CYC,
    parameter int unsigned SETTLE_CYC = WAVE_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // active power from the low-pass filter
    input wire logic [PWR_W-1:0] power_sample,
    // software settings
    input wire logic [MODE_W-1:0] operating_mode_control,
    input wire logic waveform_sample_irq_enable,
    input wire logic [DIV_W-1:0] energy_divisor,
    input wire logic [OFS_W-1:0] power_offset_trim,
    input wire logic [SCALE_W-1:0] pulse_rate_numerator,
    input wire logic [SCALE_W-1:0] pulse_rate_denominator,
    // energy readout
    input wire logic read_clear_strobe,
    output logic [VIS_W-1:0] active_energy_total,
    output logic [VIS_W-1:0] active_energy_read_clear,
    // energy events
    output logic energy_half_evt,
    output logic energy_overflow_evt,
    output logic energy_underflow_evt,
    // waveform output
    output logic [PWR_W-1:0] waveform_sample,
    output logic waveform_sample_valid,
    output logic waveform_settled,
    // calibration pulse
    output logic calibration_pulse_out
);
    function automatic logic [TRIM_W-1:0] mag(input logic [TRIM_W-1:0] v);
        return v[TRIM_W-1] ? (~v + TRIM_W'(1)) : v;
    endfunction

    logic [1:0] step_cnt_r;
    logic step;
    logic [ACC_W-1:0] acc_r, acc_base, acc_nxt, addend;
    logic [TRIM_W-1:0] trimmed, quot_mag, scaled;
    logic [DIV_W-1:0] div_eff;
    logic pos_only, neg, adding;
    logic [VIS_W-1:0] vis_old, vis_new, vis_diff;
    logic [VIS_W-1:0] adv_abs;
    logic step_d_r;
    logic [ADV_W-1:0] advance_r;
    logic half_r;

    // one accumulation every four clocks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_cnt_r <= '0;
        end else begin
            step_cnt_r <= step_cnt_r + 2'h1;
        end
    end
    assign step = (step_cnt_r == STEP_LAST);

    // offset is in 1/256 of a sample LSB
    assign trimmed = {power_sample[PWR_W-1], power_sample, {TRIM_FRAC{1'b0}}}
        + {{(TRIM_W-OFS_W){power_offset_trim[OFS_W-1]}}, power_offset_trim};

    assign pos_only = operating_mode_control[MODE_POS_ONLY_BIT];
    assign div_eff = (energy_divisor == '0) ? DIV_W'(1) : energy_divisor;
    assign neg = trimmed[TRIM_W-1];
    // divide the magnitude so rounding is symmetric about zero
    assign quot_mag = mag(trimmed) / {{(TRIM_W-DIV_W){1'b0}}, div_eff};
    assign scaled = neg ? (~quot_mag + TRIM_W'(1)) : quot_mag;

    always_comb begin
        adding = step && !(pos_only && neg);
        addend = '0;
        if (adding) begin
            addend = {{(ACC_W-TRIM_W){scaled[TRIM_W-1]}}, scaled};
        end
        // a clear in a step cycle still keeps that step's sample
        acc_base = acc_r;
        if (read_clear_strobe) begin
            acc_base = {{VIS_W{1'b0}}, acc_r[VIS_LSB-1:0]};
        end
        acc_nxt = acc_base + addend;
        vis_old = acc_base[ACC_W-1:VIS_LSB];
        vis_new = acc_nxt[ACC_W-1:VIS_LSB];
        vis_diff = vis_new - vis_old;
        adv_abs = vis_diff[VIS_W-1] ? (~vis_diff + VIS_W'(1)) : vis_diff;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end
    assign active_energy_total = acc_r[ACC_W-1:VIS_LSB];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            active_energy_read_clear <= '0;
        end else if (read_clear_strobe) begin
            active_energy_read_clear <= acc_r[ACC_W-1:VIS_LSB];
        end
    end

    // wrap seen only when the add itself crosses full scale
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            energy_overflow_evt <= 1'b0;
            energy_underflow_evt <= 1'b0;
        end else begin
            energy_overflow_evt <= adding && !addend[ACC_W-1]
                && !vis_old[VIS_W-1] && vis_new[VIS_W-1];
            energy_underflow_evt <= adding && addend[ACC_W-1]
                && vis_old[VIS_W-1] && !vis_new[VIS_W-1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            half_r <= 1'b0;
            energy_half_evt <= 1'b0;
        end else begin
            half_r <= vis_new[VIS_W-1] ^ vis_new[VIS_W-2];
            energy_half_evt <= (vis_new[VIS_W-1] ^ vis_new[VIS_W-2]) && !half_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_d_r <= 1'b0;
            advance_r <= '0;
        end else begin
            step_d_r <= step;
            advance_r <= ADV_W'(adv_abs);
        end
    end

    aeap_pulse_gen #(
        .FIXED_WIDTH_CYC(FIXED_WIDTH_CYC),
        .SLOW_PERIOD_CYC(SLOW_PERIOD_CYC)
    ) u_pulse (
        .clk_sys(clk_sys),
        .srst(srst),
        .step_i(step_d_r),
        .advance(advance_r),
        .pulse_rate_numerator(pulse_rate_numerator),
        .pulse_rate_denominator(pulse_rate_denominator),
        .calibration_pulse_out(calibration_pulse_out)
    );

    aeap_wave_tap #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_wave (
        .clk_sys(clk_sys),
        .srst(srst),
        .select_active(waveform_sample_irq_enable
            && operating_mode_control[MODE_WSRC_HI:MODE_WSRC_LO] == WSRC_ACTIVE_POWER),
        .rate_sel(operating_mode_control[MODE_WRATE_HI:MODE_WRATE_LO]),
        .power_word(trimmed[TRIM_W-2:TRIM_FRAC]),
        .waveform_sample(waveform_sample),
        .waveform_sample_valid(waveform_sample_valid),
        .waveform_settled(waveform_settled)
    );
endmodule
`default_nettype wire

//--- tb/aeap_energy_core_properties.sv
// assertion checker for the active energy accumulator ports
`timescale 1ns/1ps
`default_nettype none
module aeap_energy_core_properties
    import aeap_pkg::*;
#(
    parameter int unsigned FIXED_WIDTH_CYC = CF_FIXED_WIDTH_CYC,
    parameter int unsigned SLOW_PERIOD_CYC = CF_SLOW_PERIOD_CYC,
    parameter int unsigned SETTLE_CYC = WAVE_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // settings
    input wire logic [MODE_W-1:0] operating_mode_control,
    input wire logic waveform_sample_irq_enable,
    input wire logic [SCALE_W-1:0] pulse_rate_numerator,
    input wire logic [SCALE_W-1:0] pulse_rate_denominator,
    // energy and events
    input wire logic read_clear_strobe,
    input wire logic [VIS_W-1:0] active_energy_total,
    input wire logic [VIS_W-1:0] active_energy_read_clear,
    input wire logic energy_half_evt,
    input wire logic energy_overflow_evt,
    input wire logic energy_underflow_evt,
    // waveform and pulse
    input wire logic waveform_sample_valid,
    input wire logic waveform_settled,
    input wire logic calibration_pulse_out
);
    logic [SCALE_W:0] eff_n;
    logic [SCALE_W:0] eff_d;
    logic ratio_one;
    logic sel;
    logic [CNT_W-1:0] hi_cnt_r;

    // zero scaling value counts as one, then plus one
    assign eff_n = (pulse_rate_numerator == 12'h000) ? 13'h0002 :
        {1'b0, pulse_rate_numerator} + 13'h0001;
    assign eff_d = (pulse_rate_denominator == 12'h000) ? 13'h0002 :
        {1'b0, pulse_rate_denominator} + 13'h0001;
    assign ratio_one = eff_n >= eff_d;
    assign sel = waveform_sample_irq_enable &&
        operating_mode_control[MODE_WSRC_HI:MODE_WSRC_LO] == WSRC_ACTIVE_POWER;

    // width counter, since repetition cannot span 64 cycles
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hi_cnt_r <= '0;
        end else begin
            hi_cnt_r <= calibration_pulse_out ? hi_cnt_r + 1'b1 : '0;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_no_clear3;
        !read_clear_strobe [*3];
    endsequence
    property p_step_gap;
        ($changed(active_energy_total) && !$past(read_clear_strobe) && !$past(srst))
            ##0 s_no_clear3 |-> $stable(active_energy_total) ##1 $stable(active_energy_total);
    endproperty
    property p_rc_value;
        read_clear_strobe |=> active_energy_read_clear == $past(active_energy_total);
    endproperty
    property p_ovf;
        energy_overflow_evt |-> active_energy_total[23] && !$past(active_energy_total[23]);
    endproperty
    property p_unf;
        energy_underflow_evt |-> !active_energy_total[23] && $past(active_energy_total[23]);
    endproperty
    property p_half;
        energy_half_evt |-> (^active_energy_total[23:22])
            && !(^$past(active_energy_total[23:22]));
    endproperty
    property p_cf_width;
        $fell(calibration_pulse_out) && ratio_one |-> hi_cnt_r == CF_RATIO1_CYC;
    endproperty
    property p_cf_gap;
        $fell(calibration_pulse_out) && ratio_one |-> !calibration_pulse_out [*8];
    endproperty
    property p_cf_slow;
        $fell(calibration_pulse_out) && !ratio_one |->
            hi_cnt_r <= FIXED_WIDTH_CYC || 2 * hi_cnt_r <= SLOW_PERIOD_CYC;
    endproperty
    property p_wave_src;
        waveform_sample_valid |-> $past(sel);
    endproperty
    property p_wave_unsettle;
        !sel |=> !waveform_settled;
    endproperty

    a_step_gap: assert property (p_step_gap) else $error("total moved between steps");
    a_rc_value: assert property (p_rc_value) else $error("read clear value wrong");
    a_ovf: assert property (p_ovf) else $error("overflow event without wrap");
    a_unf: assert property (p_unf) else $error("underflow event without wrap");
    a_half: assert property (p_half) else $error("half event misplaced");
    a_cf_width: assert property (p_cf_width) else $error("pulse width wrong");
    a_cf_gap: assert property (p_cf_gap) else $error("pulse gap too short");
    a_cf_slow: assert property (p_cf_slow) else $error("slow pulse too wide");
    a_wave_src: assert property (p_wave_src) else $error("sample while unselected");
    a_wave_unsettle: assert property (p_wave_unsettle) else $error("settled kept");
endmodule

bind aeap_energy_core aeap_energy_core_properties #(
    .FIXED_WIDTH_CYC(FIXED_WIDTH_CYC),
    .SLOW_PERIOD_CYC(SLOW_PERIOD_CYC),
    .SETTLE_CYC(SETTLE_CYC)
) i_props (
    .clk_sys(clk_sys),
    .srst(srst),
    .operating_mode_control(operating_mode_control),
    .waveform_sample_irq_enable(waveform_sample_irq_enable),
    .pulse_rate_numerator(pulse_rate_numerator),
    .pulse_rate_denominator(pulse_rate_denominator),
    .read_clear_strobe(read_clear_strobe),
    .active_energy_total(active_energy_total),
    .active_energy_read_clear(active_energy_read_clear),
    .energy_half_evt(energy_half_evt),
    .energy_overflow_evt(energy_overflow_evt),
    .energy_underflow_evt(energy_underflow_evt),
    .waveform_sample_valid(waveform_sample_valid),
    .waveform_settled(waveform_settled),
    .calibration_pulse_out(calibration_pulse_out)
);
`default_nettype wire

//--- tb/aeap_cf_meter.sv
// calibration meter model: counts pulses and measures their width
`timescale 1ns/1ps
`default_nettype none
module aeap_cf_meter (
    // clock and control
    input wire logic clk_sys,
    input wire logic clear,
    // pulse pin
    input wire logic calibration_pulse_out,
    // results
    output var int pulse_count,
    output var int first_width,
    output var int last_width
);
    int run;

    // a pulse counts on its falling edge only, so a pulse still high is not yet counted
    always @(posedge clk_sys) begin
        if (clear) begin
            pulse_count <= 0;
            first_width <= 0;
            last_width <= 0;
            run <= 0;
        end else if (calibration_pulse_out) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulse_count <= pulse_count + 1;
            last_width <= run;
            if (pulse_count == 0) begin
                first_width <= run;
            end
            run <= 0;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_aeap_energy_core.sv
// self-checking bench for the active energy accumulator and pulse output
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_aeap_energy_core
    import aeap_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [PWR_W-1:0] power_sample = '0;
    logic [MODE_W-1:0] operating_mode_control = '0;
    logic waveform_sample_irq_enable = 1'b0;
    logic [DIV_W-1:0] energy_divisor = '0;
    logic [OFS_W-1:0] power_offset_trim = '0;
    logic [SCALE_W-1:0] pulse_rate_numerator = '0;
    logic [SCALE_W-1:0] pulse_rate_denominator = '0;
    logic read_clear_strobe = 1'b0;
    logic meter_clear = 1'b1;
    logic [VIS_W-1:0] active_energy_total;
    logic [VIS_W-1:0] active_energy_read_clear;
    logic [PWR_W-1:0] waveform_sample;
    logic waveform_sample_valid;
    logic waveform_settled;
    logic calibration_pulse_out;
    logic energy_half_evt;
    logic energy_overflow_evt;
    logic energy_underflow_evt;
    logic [2:0] evt_seen = 3'h0;
    int pulse_count;
    int first_width;
    int last_width;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // short widths keep the pulse scenarios within a few thousand cycles
    aeap_energy_core #(.FIXED_WIDTH_CYC(40), .SLOW_PERIOD_CYC(200), .SETTLE_CYC(20)) i_dut (
        .clk_sys(clk_sys),
        .srst(srst),
        .power_sample(power_sample),
        .operating_mode_control(operating_mode_control),
        .waveform_sample_irq_enable(waveform_sample_irq_enable),
        .energy_divisor(energy_divisor),
        .power_offset_trim(power_offset_trim),
        .pulse_rate_numerator(pulse_rate_numerator),
        .pulse_rate_denominator(pulse_rate_denominator),
        .read_clear_strobe(read_clear_strobe),
        .active_energy_total(active_energy_total),
        .active_energy_read_clear(active_energy_read_clear),
        .energy_half_evt(energy_half_evt),
        .energy_overflow_evt(energy_overflow_evt),
        .energy_underflow_evt(energy_underflow_evt),
        .waveform_sample(waveform_sample),
        .waveform_sample_valid(waveform_sample_valid),
        .waveform_settled(waveform_settled),
        .calibration_pulse_out(calibration_pulse_out)
    );

    aeap_cf_meter i_meter (
        .clk_sys(clk_sys),
        .clear(meter_clear),
        .calibration_pulse_out(calibration_pulse_out),
        .pulse_count(pulse_count),
        .first_width(first_width),
        .last_width(last_width)
    );

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            final_report();
        end
    end

    // sticky record of event pulses, skipped while outputs are still unknown
    always @(posedge clk_sys) begin
        if (!srst) begin
            evt_seen <= evt_seen
                | {energy_half_evt, energy_overflow_evt, energy_underflow_evt};
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        srst <= 1'b1;
        meter_clear <= 1'b1;
        cyc(16);
        srst <= 1'b0;
        meter_clear <= 1'b0;
        cyc(2);
    endtask

    // exactly k step edges see p in any window of 4k edges
    task automatic run_steps(input logic [PWR_W-1:0] p, input int k);
        @(posedge clk_sys);
        power_sample <= p;
        cyc(4 * k);
        power_sample <= '0;
        cyc(4);
    endtask

    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waveform_sample_valid !== 1'b1 && n < 4000);
    endtask

    task automatic t_accumulate();
        do_reset();
        `CHK(active_energy_total, 24'h00_0000)
        run_steps(24'h02_0000, 5);
        `CHK(active_energy_total, 24'h00_0005)
        run_steps(24'hFE_0000, 7);
        `CHK(active_energy_total, 24'hFF_FFFE)
        operating_mode_control <= 16'h8000;
        run_steps(24'hFE_0000, 3);
        `CHK(active_energy_total, 24'hFF_FFFE)
        run_steps(24'h02_0000, 2);
        `CHK(active_energy_total, 24'h00_0000)
        operating_mode_control <= 16'h0000;
    endtask

    task automatic t_divide_clear();
        do_reset();
        energy_divisor <= 8'h02;
        run_steps(24'h04_0000, 4);
        `CHK(active_energy_total, 24'h00_0004)
        energy_divisor <= 8'h01;
        power_offset_trim <= 16'h0100;
        run_steps(24'h01_FFFF, 4);
        `CHK(active_energy_total, 24'h00_0008)
        power_offset_trim <= 16'h0000;
        @(posedge clk_sys);
        read_clear_strobe <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK(active_energy_read_clear, 24'h00_0008)
        `CHK(active_energy_total, 24'h00_0000)
        @(posedge clk_sys);
        read_clear_strobe <= 1'b0;
        #1;
        `CHK(active_energy_read_clear, 24'h00_0000)
    endtask

    task automatic t_pulse_ratio();
        do_reset();
        pulse_rate_numerator <= 12'h000;
        pulse_rate_denominator <= 12'h003;
        run_steps(24'h02_0000, 8);
        cyc(1500);
        `CHK(pulse_count, 4)
        `CHK(first_width, 40)
    endtask

    task automatic t_pulse_clamp();
        do_reset();
        pulse_rate_numerator <= 12'h005;
        pulse_rate_denominator <= 12'h000;
        run_steps(24'h02_0000, 3);
        cyc(600);
        `CHK(pulse_count, 3)
        `CHK(last_width, 64)
    endtask

    task automatic t_wave();
        int n;
        do_reset();
        power_sample <= 24'h00_1234;
        waveform_sample_irq_enable <= 1'b1;
        cyc(4);
        `CHK(waveform_settled, 1'b0)
        cyc(40);
        `CHK(waveform_settled, 1'b1)
        for (int r = 0; r < 4; r++) begin
            operating_mode_control <= 16'(r) << MODE_WRATE_LO;
            wait_valid(n);
            wait_valid(n);
            wait_valid(n);
            `CHK(n, WAVE_BASE_CYC << r)
            `CHK(waveform_sample, 24'h00_1234)
        end
        waveform_sample_irq_enable <= 1'b0;
        cyc(3);
        `CHK(waveform_settled, 1'b0)
        // another source field keeps the tap idle though enabled
        operating_mode_control <= 16'h2000;
        waveform_sample_irq_enable <= 1'b1;
        cyc(30);
        `CHK(waveform_settled, 1'b0)
        waveform_sample_irq_enable <= 1'b0;
        operating_mode_control <= 16'h0000;
        power_sample <= '0;
        // energy stayed far from half scale, so no event may have fired
        `CHK(evt_seen, 3'h0)
    endtask

    initial begin
        t_accumulate();
        t_divide_clear();
        t_pulse_ratio();
        t_pulse_clamp();
        t_wave();
        final_report();
    end
endmodule
`default_nettype wire
